// ===== rtl/clrb_pkg.sv
// Operation
// - Control byte: select, access, mode, decimal flag
// - Access field: latch, low, high, low-then-high
// - Access zero latches selected count immediately
// - Latch leaves counting alone; read returns hold
// - Host trusts direct reads only when stopped
// - Two-byte access toggles low then high
// - Readback: bits 7,6 set; latch, status, selects
// - Select bits 1..3 pick counters 0..2
// - Count-latch low latches selected counters together
// - Status-latch low captures status for next read
// - Status: output, null count, programmed fields
// - Status output bit is present pin level
// - Null count until written count transferred
// - Decimal bit: zero binary, one decimal; counter here always counts binary
// - Status, low, high order after full readback
// - Further latches ignored until hold read
// - Pending status read before latched count
// - Calibration potentiometers power up at midpoint
// - Host loads calibration values after reset; here loads come in on potWr, not through clrb_host
package clrb_pkg;
	localparam int          NUM_COUNTERS   = 3;
	localparam int          NUM_POTS       = 4;
	localparam logic [1:0]  ADDR_CONTROL   = 2'h3;
	localparam int          SEL_HI_BIT     = 7;
	localparam int          SEL_LO_BIT     = 6;
	localparam int          ACC_HI_BIT     = 5;
	localparam int          ACC_LO_BIT     = 4;
	localparam int          MODE_BIT_TWO   = 3;
	localparam int          MODE_BIT_ZERO  = 1;
	localparam int          DEC_BIT        = 0;
	localparam int          RB_COUNT_N_BIT = 5;
	localparam int          RB_STATUS_N_BIT = 4;
	localparam int          RB_PICK_LO_BIT = 1;
	localparam int          ST_OUT_BIT     = 7;
	localparam int          ST_NULL_BIT    = 6;
	localparam logic [1:0]  SEL_READBACK   = 2'h3;
	localparam logic [1:0]  ACC_LATCH      = 2'h0;
	localparam logic [1:0]  ACC_LOW        = 2'h1;
	localparam logic [1:0]  ACC_HIGH       = 2'h2;
	localparam logic [1:0]  ACC_BOTH       = 2'h3;
	localparam logic [7:0]  POT_MIDPOINT   = 8'h80;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [5:0]  CTRL_RESET     = 6'h00;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	// AXI4-Lite map of the host controller (byte offsets)
	localparam logic [7:0]  REG_CMD        = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [7:0]  REG_RDATA      = 8'h08;
	localparam int          CMD_START_BIT  = 31;
	localparam int          CMD_WRITE_BIT  = 30;
	localparam int          CMD_ADDR_LO    = 8;
	localparam logic [1:0]  AXI_OKAY       = 2'b00;
	localparam logic [1:0]  AXI_SLVERR     = 2'b10;
endpackage : clrb_pkg

// ===== rtl/clrb_if.sv
`timescale 1ns/1ps
interface clrb_if;
	logic       sel;
	logic       wr;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rvalid;
	modport dev  (input sel, input wr, input addr, input wdata, output rdata, output rvalid);
	modport host (output sel, output wr, output addr, output wdata, input rdata, input rvalid);
endinterface : clrb_if

// ===== rtl/clrb_device.sv
`timescale 1ns/1ps
module clrb_device
	import clrb_pkg::*;
#(
	parameter int COUNT_W = 16,
	parameter int POT_W = 8
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	clrb_if.dev                             bus,
	input  wire logic [NUM_COUNTERS-1:0]    countEn,
	input  wire logic [NUM_COUNTERS-1:0]    outLevel,
	input  wire logic [NUM_COUNTERS-1:0]    loadDone,
	input  wire logic [NUM_POTS-1:0]        potWr,
	input  wire logic [POT_W-1:0]           potData,
	output logic [NUM_COUNTERS*COUNT_W-1:0] liveCount,
	output logic [NUM_COUNTERS*COUNT_W-1:0] loadValue,
	output logic [NUM_COUNTERS-1:0]         loadStrobe,
	output logic [NUM_COUNTERS*6-1:0]       ctrlOut,
	output logic [NUM_POTS*POT_W-1:0]       potValue
);
	// Counting element is fixed at 16 bits; pot reset must be the true midpoint
	if (COUNT_W != 16 || POT_W != $bits(POT_MIDPOINT)) begin : gBadWidth
		$error("clrb_device: unsupported widths");
	end

	logic       busWrite;
	logic       busRead;
	logic       isCtrl;
	logic       isReadback;
	assign busWrite   = bus.sel && bus.wr;
	assign busRead    = bus.sel && !bus.wr;
	assign isCtrl     = busWrite && bus.addr == ADDR_CONTROL;
	assign isReadback = isCtrl && bus.wdata[SEL_HI_BIT:SEL_LO_BIT] == SEL_READBACK;

	logic [7:0] rdMux [NUM_COUNTERS];
	logic [NUM_COUNTERS-1:0] rdHit;

	genvar g;
	generate
		for (g = 0; g < NUM_COUNTERS; g++) begin : gCnt
			logic [15:0] count;
			logic [15:0] hold;
			logic        holdValid;
			logic        holdHiOnly;
			logic [7:0]  statusByte;
			logic        statusValid;
			logic [5:0]  ctrl;
			logic        nullCount;
			logic        rdToggle;
			logic        wrToggle;
			logic [7:0]  loLoad;
			logic        progHit;
			logic        plainLatch;
			logic        rbLatch;
			logic        rbStatus;
			logic        doLatch;
			logic        access;
			logic [1:0]  acc;
			logic [15:0] src;
			logic        lastByte;

			assign acc        = ctrl[5:4];
			assign progHit    = isCtrl && !isReadback && bus.wdata[SEL_HI_BIT:SEL_LO_BIT] == 2'(g);
			assign plainLatch = progHit && bus.wdata[ACC_HI_BIT:ACC_LO_BIT] == ACC_LATCH;
			assign rbLatch    = isReadback && bus.wdata[RB_PICK_LO_BIT+g]
				&& !bus.wdata[RB_COUNT_N_BIT];
			assign rbStatus   = isReadback && bus.wdata[RB_PICK_LO_BIT+g]
				&& !bus.wdata[RB_STATUS_N_BIT];
			assign doLatch    = (plainLatch || rbLatch) && !holdValid;
			assign access     = bus.sel && bus.addr == 2'(g);
			assign src        = holdValid ? hold : count;
			// Last byte of the current pair under the programmed access type
			assign lastByte   = acc != ACC_BOTH || rdToggle || holdHiOnly;

			// Counting element; count enable stands in for gate and clock
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					count <= COUNT_RESET;
				end else if (loadDone[g]) begin
					count <= loadValue[g*COUNT_W +: COUNT_W];
				end else if (countEn[g]) begin
					count <= count - 16'h0001;
				end
			end

			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					ctrl <= CTRL_RESET;
				end else if (progHit && !plainLatch) begin
					ctrl <= bus.wdata[ACC_HI_BIT:DEC_BIT];
				end
			end

			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					hold       <= COUNT_RESET;
					holdValid  <= 1'b0;
					holdHiOnly <= 1'b0;
				end else if (doLatch) begin
					hold       <= count;
					holdValid  <= 1'b1;
					holdHiOnly <= 1'b0;
				end else if (access && busRead && !statusValid && holdValid) begin
					if (lastByte) begin
						holdValid  <= 1'b0;
						holdHiOnly <= 1'b0;
					end else begin
						holdHiOnly <= 1'b1;
					end
				end
			end

			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					statusByte  <= BYTE_ZERO;
					statusValid <= 1'b0;
				end else if (rbStatus && !statusValid) begin
					// Pin level and pending load seen in this very cycle
					statusByte  <= {outLevel[g], nullCount, ctrl};
					statusValid <= 1'b1;
				end else if (access && busRead && statusValid) begin
					statusValid <= 1'b0;
				end
			end

			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					rdToggle <= 1'b0;
					wrToggle <= 1'b0;
					loLoad   <= BYTE_ZERO;
					nullCount <= 1'b0;
					loadStrobe[g] <= 1'b0;
					loadValue[g*COUNT_W +: COUNT_W] <= COUNT_RESET;
				end else begin
					loadStrobe[g] <= 1'b0;
					if (progHit && !plainLatch) begin
						rdToggle <= 1'b0;
						wrToggle <= 1'b0;
					end else if (access && busRead && !statusValid) begin
						rdToggle <= acc == ACC_BOTH && !lastByte;
					end else if (access && busWrite) begin
						if (acc == ACC_BOTH && !wrToggle) begin
							loLoad   <= bus.wdata;
							wrToggle <= 1'b1;
						end else begin
							wrToggle <= 1'b0;
							loadStrobe[g] <= 1'b1;
							nullCount <= 1'b1;
							case (acc)
								ACC_LOW:  loadValue[g*COUNT_W +: COUNT_W] <= {BYTE_ZERO, bus.wdata};
								ACC_HIGH: loadValue[g*COUNT_W +: COUNT_W] <= {bus.wdata, BYTE_ZERO};
								default:  loadValue[g*COUNT_W +: COUNT_W] <= {bus.wdata, loLoad};
							endcase
						end
					end
					if (loadDone[g] && !(access && busWrite)) begin
						nullCount <= 1'b0;
					end
				end
			end

			always_comb begin
				rdHit[g] = access && busRead;
				if (statusValid) begin
					rdMux[g] = statusByte;
				end else if (acc == ACC_HIGH || (acc == ACC_BOTH && (rdToggle || holdHiOnly))) begin
					rdMux[g] = src[15:8];
				end else begin
					rdMux[g] = src[7:0];
				end
			end

			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					liveCount[g*COUNT_W +: COUNT_W] <= COUNT_RESET;
					ctrlOut[g*6 +: 6] <= CTRL_RESET;
				end else begin
					liveCount[g*COUNT_W +: COUNT_W] <= count;
					ctrlOut[g*6 +: 6] <= ctrl;
				end
			end
		end

		for (g = 0; g < NUM_POTS; g++) begin : gPot
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					potValue[g*POT_W +: POT_W] <= POT_W'(POT_MIDPOINT);
				end else if (potWr[g]) begin
					potValue[g*POT_W +: POT_W] <= potData;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.rdata  <= BYTE_ZERO;
			bus.rvalid <= 1'b0;
		end else begin
			bus.rvalid <= |rdHit;
			bus.rdata  <= BYTE_ZERO;
			for (int i = 0; i < NUM_COUNTERS; i++) begin
				if (rdHit[i]) begin
					bus.rdata <= rdMux[i];
				end
			end
		end
	end
endmodule : clrb_device

// ===== rtl/clrb_host.sv
`timescale 1ns/1ps
module clrb_host
	import clrb_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	clrb_if.host             bus,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	typedef enum logic [1:0] {
		CLRB_IDLE = 2'b00,
		CLRB_ISSUE = 2'b01,
		CLRB_WAIT = 2'b10
	} clrb_state_t;

	clrb_state_t state;
	logic        awHeld;
	logic        wHeld;
	logic [7:0]  awAddr;
	logic [31:0] wWord;
	logic        busy;
	logic [7:0]  lastByte;
	logic        doneFlag;
	logic        startCmd;

	assign busy = state != CLRB_IDLE;
	// Host sequencing of pairs is software's job via REG_CMD; calibration loads use potWr, not the host
	assign startCmd = awHeld && wHeld && !bvalid && awAddr == REG_CMD
		&& wWord[CMD_START_BIT] && !busy;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld  <= 1'b0;
			wHeld   <= 1'b0;
			awready <= 1'b1;
			wready  <= 1'b1;
			awAddr  <= BYTE_ZERO;
			wWord   <= 32'h0000_0000;
			bvalid  <= 1'b0;
			bresp   <= AXI_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHeld  <= 1'b1;
				awAddr  <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wHeld  <= 1'b1;
				wWord  <= wdata;
				wready <= 1'b0;
			end
			if (awHeld && wHeld && !bvalid) begin
				bvalid  <= 1'b1;
				bresp   <= (awAddr == REG_CMD && wstrb != 4'h0) ? AXI_OKAY : AXI_SLVERR;
				awHeld  <= 1'b0;
				wHeld   <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// One byte access per command; the reply is kept for software
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= CLRB_IDLE;
			bus.sel   <= 1'b0;
			bus.wr    <= 1'b0;
			bus.addr  <= 2'h0;
			bus.wdata <= BYTE_ZERO;
			lastByte  <= BYTE_ZERO;
			doneFlag  <= 1'b0;
		end else begin
			case (state)
				CLRB_IDLE: begin
					if (startCmd) begin
						bus.sel   <= 1'b1;
						bus.wr    <= wWord[CMD_WRITE_BIT];
						bus.addr  <= wWord[CMD_ADDR_LO +: 2];
						bus.wdata <= wWord[7:0];
						doneFlag  <= 1'b0;
						state     <= CLRB_ISSUE;
					end
				end
				CLRB_ISSUE: begin
					bus.sel <= 1'b0;
					state   <= bus.wr ? CLRB_IDLE : CLRB_WAIT;
					doneFlag <= bus.wr;
				end
				CLRB_WAIT: begin
					if (bus.rvalid) begin
						lastByte <= bus.rdata;
						doneFlag <= 1'b1;
						state    <= CLRB_IDLE;
					end
				end
				default: state <= CLRB_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= AXI_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= AXI_OKAY;
			case (araddr)
				REG_STATUS: rdata <= {30'h0000_0000, doneFlag, busy};
				REG_RDATA:  rdata <= {24'h00_0000, lastByte};
				REG_CMD:    rdata <= 32'h0000_0000;
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= AXI_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule : clrb_host

// ===== tb/clrb_properties.sv
`timescale 1ns/1ps
module clrb_properties
	import clrb_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       sel,
	input wire logic       wr,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       rvalid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [5:0]              ctrlSeen [NUM_COUNTERS];
	logic [NUM_COUNTERS-1:0] stPend;
	logic                    stHit;
	logic [5:0]              stExp;
	wire                     cmdWr = sel && wr && addr == ADDR_CONTROL;
	wire                     rdReq = sel && !wr && addr != ADDR_CONTROL;
	wire                     stCmd = cmdWr && wdata[7:6] == SEL_READBACK && !wdata[RB_STATUS_N_BIT];
	// Latch commands do not reprogram, so they are not recorded
	always_ff @(posedge ref_clk or negedge rst_n) begin
		for (int i = 0; i < NUM_COUNTERS; i++) begin
			if (!rst_n) begin
				ctrlSeen[i] <= CTRL_RESET;
			end else if (cmdWr && wdata[7:6] == 2'(i) && wdata[5:4] != ACC_LATCH) begin
				ctrlSeen[i] <= wdata[5:0];
			end
		end
	end
	// Only the low six bits are predictable here; pin level and null count are not visible
	always_ff @(posedge ref_clk or negedge rst_n) begin
		for (int i = 0; i < NUM_COUNTERS; i++) begin
			if (!rst_n) begin
				stPend[i] <= 1'b0;
			end else if (stCmd && wdata[RB_PICK_LO_BIT + i]) begin
				stPend[i] <= 1'b1;
			end else if (rdReq && addr == 2'(i)) begin
				stPend[i] <= 1'b0;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stHit <= 1'b0;
			stExp <= CTRL_RESET;
		end else begin
			stHit <= rdReq && stPend[addr];
			stExp <= ctrlSeen[addr];
		end
	end
	sequence answer;
		rvalid ##1 !rvalid;
	endsequence
	rd_answer_a: assert property (rdReq |=> answer)
		else $error("read not answered");
	answer_cause_a: assert property (rvalid |-> $past(sel && !wr))
		else $error("answer without read");
	write_silent_a: assert property (sel && wr |=> !rvalid)
		else $error("answer to a write");
	host_spacing_a: assert property (sel |=> !sel)
		else $error("accesses back to back");
	answer_gap_a: assert property (rvalid |-> !sel)
		else $error("access during answer");
	status_echo_a: assert property (stHit |-> rvalid && rdata[5:0] == stExp)
		else $error("status fields wrong");
	status_dec_a: assert property (stHit |-> rdata[DEC_BIT] == stExp[DEC_BIT])
		else $error("status decimal bit wrong");
	readback_form_a: assert property (stCmd |-> !wdata[DEC_BIT])
		else $error("readback bit 0 set");
endmodule : clrb_properties

// ===== tb/counter_latch_readback_tb_top.sv
`timescale 1ns/1ps
module counter_latch_readback_tb_top
	import clrb_pkg::*;
;
	logic        ref_clk = 1'b0, rst_n = 1'b0;
	logic [2:0]  countEn = '0, outLevel = '0, loadDone = '0;
	logic [3:0]  potWr = '0;
	logic [7:0]  potData = '0, awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, potValue;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [47:0] liveCount, loadValue;
	logic [17:0] ctrlOut;
	logic [2:0]  loadStrobe;
	int          err_total = 0, comparisons = 0, cycles = 0, strobes = 0;
	clrb_if lnk();
	clrb_device i_clrb_device (.ref_clk(ref_clk), .rst_n(rst_n), .bus(lnk.dev), .countEn(countEn),
		.outLevel(outLevel), .loadDone(loadDone), .potWr(potWr), .potData(potData),
		.liveCount(liveCount), .loadValue(loadValue), .loadStrobe(loadStrobe),
		.ctrlOut(ctrlOut), .potValue(potValue));
	clrb_host i_clrb_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(lnk.host), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));
	clrb_properties i_clrb_properties (.ref_clk(ref_clk), .rst_n(rst_n), .sel(lnk.sel),
		.wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .rvalid(lnk.rvalid));
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		strobes += $countones(loadStrobe);
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] resp);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check("bresp", 32'(resp), 32'(bresp));
	endtask : axi_wr
	task automatic axi_rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	// Polling busy keeps a new command from being dropped by a busy controller
	task automatic lnk_op(logic w, logic [1:0] a, logic [7:0] b, output logic [7:0] got);
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(REG_CMD, {1'b1, w, 20'h0_0000, a, b}, AXI_OKAY);
		do axi_rd(REG_STATUS, d, r); while (d[0] !== 1'b0);
		axi_rd(REG_RDATA, d, r);
		got = d[7:0];
	endtask : lnk_op
	task automatic wrb(logic [1:0] a, logic [7:0] b);
		logic [7:0] g;
		lnk_op(1'b1, a, b, g);
	endtask : wrb
	task automatic rdb(string what, logic [1:0] a, logic [7:0] exp);
		logic [7:0] g;
		lnk_op(1'b0, a, 8'h00, g);
		check(what, 32'(exp), 32'(g));
	endtask : rdb
	task automatic pulse(input logic toLoad, input logic [2:0] v, input int n);
		@(posedge ref_clk);
		if (toLoad) begin
			loadDone <= v;
		end else begin
			countEn <= v;
		end
		repeat (n) @(posedge ref_clk);
		loadDone <= 3'h0;
		countEn <= 3'h0;
	endtask : pulse
	task automatic t_pots();
		check("pots", {4{POT_MIDPOINT}}, potValue);
		@(posedge ref_clk);
		potData <= 8'h3c;
		potWr <= 4'h2;
		@(posedge ref_clk);
		potWr <= 4'h0;
		@(posedge ref_clk);
		check("pot1", 32'h8080_3c80, potValue);
	endtask : t_pots
	task automatic t_status();
		@(posedge ref_clk);
		outLevel <= 3'h1;
		wrb(ADDR_CONTROL, 8'h34);
		wrb(2'h0, 8'h34);
		check("strobe lo", 32'h0000_0000, 32'(strobes));
		wrb(2'h0, 8'h12);
		check("strobe hi", 32'h0000_0001, 32'(strobes));
		check("loadValue", 32'h0000_1234, 32'(loadValue[15:0]));
		wrb(ADDR_CONTROL, 8'he2);
		rdb("st null", 2'h0, 8'hf4);
		rdb("old lo", 2'h0, 8'h00);
		rdb("old hi", 2'h0, 8'h00);
		pulse(1'b1, 3'h1, 1);
		outLevel <= 3'h0;
		wrb(ADDR_CONTROL, 8'he2);
		rdb("st loaded", 2'h0, 8'h34);
		wrb(ADDR_CONTROL, 8'h7b);
		wrb(ADDR_CONTROL, 8'he4);
		rdb("st dec", 2'h1, 8'h3b);
	endtask : t_status
	task automatic t_latch();
		wrb(ADDR_CONTROL, 8'h00);
		pulse(1'b0, 3'h1, 10);
		wrb(ADDR_CONTROL, 8'h00);
		rdb("hold lo", 2'h0, 8'h34);
		rdb("hold hi", 2'h0, 8'h12);
		check("live", 32'h0000_122a, 32'(liveCount[15:0]));
		rdb("live lo", 2'h0, 8'h2a);
		rdb("live hi", 2'h0, 8'h12);
	endtask : t_latch
	task automatic t_readback();
		wrb(ADDR_CONTROL, 8'hc2);
		rdb("rb st", 2'h0, 8'h34);
		rdb("rb lo", 2'h0, 8'h2a);
		rdb("rb hi", 2'h0, 8'h12);
		wrb(ADDR_CONTROL, 8'h00);
		pulse(1'b0, 3'h1, 5);
		wrb(ADDR_CONTROL, 8'he2);
		rdb("late st", 2'h0, 8'h34);
		rdb("late lo", 2'h0, 8'h2a);
		rdb("late hi", 2'h0, 8'h12);
		wrb(ADDR_CONTROL, 8'hb4);
		wrb(2'h2, 8'hcd);
		wrb(2'h2, 8'hab);
		wrb(2'h1, 8'h56);
		wrb(2'h1, 8'h78);
		pulse(1'b1, 3'h6, 1);
		wrb(ADDR_CONTROL, 8'hdc);
		pulse(1'b0, 3'h7, 3);
		rdb("ctr1 lo", 2'h1, 8'h56);
		rdb("ctr1 hi", 2'h1, 8'h78);
		rdb("ctr2 lo", 2'h2, 8'hcd);
		rdb("ctr2 hi", 2'h2, 8'hab);
		rdb("ctr0 lo", 2'h0, 8'h22);
		rdb("ctr0 hi", 2'h0, 8'h12);
	endtask : t_readback
	task automatic t_access();
		wrb(ADDR_CONTROL, 8'h94);
		rdb("lo only", 2'h2, 8'hca);
		wrb(ADDR_CONTROL, 8'ha4);
		rdb("hi only", 2'h2, 8'hab);
		check("ctrlOut", 32'h0000_0024, 32'(ctrlOut[17:12]));
		wrb(ADDR_CONTROL, 8'he8);
		rdb("st hi only", 2'h2, 8'h24);
	endtask : t_access
	task automatic t_axi_err();
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(8'h0c, 32'h0000_0000, AXI_SLVERR);
		axi_rd(8'h0c, d, r);
		check("rresp", 32'(AXI_SLVERR), 32'(r));
	endtask : t_axi_err
	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_pots();
		t_status();
		t_latch();
		t_readback();
		t_access();
		t_axi_err();
		finish_test();
	end
endmodule : counter_latch_readback_tb_top
